//--- verilog/wdt_cfg.svh
// Contract
// - expiry resets cpu or raises irq15, jumper-selected
// - enable-port write enables, loads interval code
// - any write to disable port stops the watchdog
// - timeout within five percent of nominal
// - code f=2s, each lower code adds 2s
// - sixteen levels from 2 up to 32 seconds
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// isa i/o port map, full 16-bit decode
`define WDT_ADDR_ENABLE 16'h0443
`define WDT_ADDR_DISABLE 16'h0080

// clock
`define WDT_CLK_MHZ 50
`define WDT_CLK_PERIOD_NS 20

// time base: a 100 ms tick, one interval step is 2000 ms
`define WDT_TICK_MS 100
`define WDT_TICK_CYCLES (`WDT_TICK_MS * 1000 * `WDT_CLK_MHZ)
`define WDT_STEP_MS 2000
`define WDT_TICKS_PER_STEP (`WDT_STEP_MS / `WDT_TICK_MS)
`define WDT_CODE_LEVELS 16
`define WDT_MAX_TICKS 320

// cpu reset pulse, least time rounded up to whole cycles
`define WDT_RESET_PULSE_NS 1000
`define WDT_RESET_PULSE_CYCLES \
  ((`WDT_RESET_PULSE_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)

// reset values
`define WDT_REMAIN_RESET 9'h000
`define WDT_PULSE_RESET 6'h00

`endif

//--- verilog/wdt_pkg.sv
`default_nettype none
package wdt_pkg;
  typedef enum logic [2:0] {
    st_off = 3'b001,
    st_run = 3'b010,
    st_fired = 3'b100
  } wdt_state_t;

  typedef enum logic {
    act_reset = 1'b0,
    act_irq = 1'b1
  } wdt_action_t;
endpackage
`default_nettype wire

//--- verilog/wdt_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module wdt_prescaler #(
  parameter int tick_cycles = 5000000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  output logic tick
);
  localparam int cw = $clog2(tick_cycles);
  localparam logic [cw-1:0] last = cw'(tick_cycles - 1);

  logic [cw-1:0] count;
  logic [cw-1:0] next_count;

  // clearing realigns the tick to the refresh write, so the countdown is exact
  always_comb begin
    next_count = count + cw'(1);
    if (clear || count == last) begin
      next_count = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign tick = (count == last) && !clear;
endmodule
`default_nettype wire

//--- verilog/io_port_watchdog_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "wdt_cfg.svh"
module io_port_watchdog_timer #(
  parameter int tick_cycles = `WDT_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_data,
  input wire logic io_write_n,
  input wire logic io_aen,
  input wire logic timeout_action_select_jumper,
  output logic cpu_reset_req,
  output logic irq15,
  output logic wdt_enabled
);
  localparam int ticks_per_step = `WDT_TICKS_PER_STEP;
  localparam int pulse_cycles = `WDT_RESET_PULSE_CYCLES;
  localparam logic [5:0] pulse_load = 6'(pulse_cycles);
  localparam logic [15:0] addr_enable = `WDT_ADDR_ENABLE;
  localparam logic [15:0] addr_disable = `WDT_ADDR_DISABLE;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: isa strobes are asynchronous to mclk

  logic [15:0] addr_s1, addr_s2;
  logic [7:0] data_s1, data_s2;
  logic wr_n_s1, wr_n_s2, wr_n_prev;
  logic aen_s1, aen_s2;
  logic jumper_s1, jumper_s2;

  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_s1 <= 16'h0000;
      addr_s2 <= 16'h0000;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
      wr_n_s1 <= 1'b1;
      wr_n_s2 <= 1'b1;
      wr_n_prev <= 1'b1;
      aen_s1 <= 1'b1;
      aen_s2 <= 1'b1;
      jumper_s1 <= 1'b0;
      jumper_s2 <= 1'b0;
    end else begin
      addr_s1 <= io_addr;
      addr_s2 <= addr_s1;
      data_s1 <= io_data;
      data_s2 <= data_s1;
      wr_n_s1 <= io_write_n;
      wr_n_s2 <= wr_n_s1;
      wr_n_prev <= wr_n_s2;
      aen_s1 <= io_aen;
      aen_s2 <= aen_s1;
      jumper_s1 <= timeout_action_select_jumper;
      jumper_s2 <= jumper_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode on the falling strobe edge; address and data are set up by then,
  // and aen high marks a dma cycle that no i/o slave may answer

  logic wr_start;
  logic en_write;
  logic dis_write;
  wdt_pkg::wdt_action_t action;

  assign wr_start = wr_n_prev && !wr_n_s2 && !aen_s2;
  assign en_write = wr_start && (addr_s2 == addr_enable);
  assign dis_write = wr_start && (addr_s2 == addr_disable);
  // open jumper means cpu reset, the default fitting
  assign action = jumper_s2 ? wdt_pkg::act_irq : wdt_pkg::act_reset;

  // code f is one step, each lower code one step more, code 0 is the 32 s top
  function automatic logic [8:0] interval_ticks(input logic [3:0] code);
    logic [4:0] steps;
    steps = 5'(`WDT_CODE_LEVELS) - {1'b0, code};
    interval_ticks = 9'(steps) * 9'(ticks_per_step);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // time base

  logic tick;

  wdt_prescaler #(
    .tick_cycles(tick_cycles)
  ) u_prescaler (
    .mclk(mclk),
    .rst(rst),
    .clear(en_write),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // countdown and expiry

  wdt_pkg::wdt_state_t state, next_state;
  logic [8:0] remain, next_remain;
  logic [5:0] pulse, next_pulse;
  logic next_irq;
  logic expire;

  // a port write in the expiry cycle wins: the host was in time, and a disable
  // must not leave a reset pulse behind; foreign writes do not delay expiry
  assign expire = (state == wdt_pkg::st_run) && tick && (remain == 9'h001)
    && !en_write && !dis_write;

  always_comb begin
    next_state = state;
    next_remain = remain;
    next_irq = irq15;
    next_pulse = (pulse != 6'h00) ? pulse - 6'h01 : 6'h00;
    unique case (state)
      wdt_pkg::st_off: begin
        next_remain = `WDT_REMAIN_RESET;
      end
      wdt_pkg::st_run: begin
        if (tick && remain != 9'h001) begin
          next_remain = remain - 9'h001;
        end else if (expire) begin
          next_state = wdt_pkg::st_fired;
          next_remain = `WDT_REMAIN_RESET;
          if (action == wdt_pkg::act_irq) begin
            next_irq = 1'b1;
          end else begin
            next_pulse = pulse_load;
          end
        end
      end
      wdt_pkg::st_fired: begin
        // a cpu reset ends the watch; an interrupt stays up until the host writes the enable or disable port
        if (pulse == 6'h01) begin
          next_state = wdt_pkg::st_off;
        end
      end
    endcase
    if (en_write) begin
      next_state = wdt_pkg::st_run;
      next_remain = interval_ticks(data_s2[3:0]);
      next_irq = 1'b0;
    end else if (dis_write) begin
      next_state = wdt_pkg::st_off;
      next_remain = `WDT_REMAIN_RESET;
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= wdt_pkg::st_off;
      remain <= `WDT_REMAIN_RESET;
      pulse <= `WDT_PULSE_RESET;
      irq15 <= 1'b0;
    end else begin
      state <= next_state;
      remain <= next_remain;
      pulse <= next_pulse;
      irq15 <= next_irq;
    end
  end

  assign cpu_reset_req = (pulse != 6'h00);
  assign wdt_enabled = (state == wdt_pkg::st_run);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_enable_write_loads: assert property (
    en_write |=> state == wdt_pkg::st_run && remain == interval_ticks($past(data_s2[3:0])))
    else $error("enable write did not load the interval");

  a_code_f_interval: assert property (
    en_write && data_s2[3:0] == 4'hf |=> remain == 9'(ticks_per_step))
    else $error("code f is not one step");

  a_disable_write_stops: assert property (
    dis_write && !en_write |=> state == wdt_pkg::st_off && !irq15)
    else $error("disable write did not stop the watchdog");

  a_off_stays_quiet: assert property (
    state == wdt_pkg::st_off && !en_write |=> !$rose(irq15) && !$rose(cpu_reset_req))
    else $error("action while disabled");

  a_expiry_resets_cpu: assert property (
    expire && action == wdt_pkg::act_reset
      |=> cpu_reset_req[*8] ##42 cpu_reset_req ##1 !cpu_reset_req && !irq15)
    else $error("reset expiry did not pulse cpu reset");

  a_expiry_raises_irq: assert property (
    expire && action == wdt_pkg::act_irq |=> irq15 && !cpu_reset_req)
    else $error("irq expiry did not raise irq15");

  a_tick_counts_down: assert property (
    state == wdt_pkg::st_run && tick && remain > 9'h001 && !wr_start
      |=> remain == $past(remain) - 9'h001)
    else $error("countdown missed a tick");

  a_remain_in_range: assert property (
    state == wdt_pkg::st_run |-> remain != 9'h000 && remain <= 9'(`WDT_MAX_TICKS))
    else $error("remaining ticks out of range");

  a_reset_leaves_off: assert property (
    $past(rst) |-> state == wdt_pkg::st_off && !irq15 && !cpu_reset_req)
    else $error("watchdog not disabled after reset");

  a_pulse_ends_off: assert property (
    $fell(cpu_reset_req) && $past(state) == wdt_pkg::st_fired && !$past(en_write)
      |-> state == wdt_pkg::st_off)
    else $error("cpu reset pulse did not end the watch");

  a_irq_holds_level: assert property (
    irq15 && !en_write && !dis_write |=> irq15)
    else $error("irq15 dropped without a host write");

  a_refresh_restarts: assert property (
    en_write |=> wdt_enabled && !irq15 && !expire)
    else $error("enable write did not restart the watch");

  a_expiry_stops_watch: assert property (
    expire |=> !wdt_enabled)
    else $error("watchdog still counting after expiry");
endmodule
`default_nettype wire

//--- tb/isa_host.sv
`timescale 1ns/100ps
`default_nettype none
module isa_host (
  input wire logic mclk,
  output logic [15:0] io_addr,
  output logic [7:0] io_data,
  output logic io_write_n,
  output logic io_aen
);
  initial begin
    io_addr <= 16'hffff;
    io_data <= 8'hff;
    io_write_n <= 1'b1;
    io_aen <= 1'b1;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_write(a, d, 1'b0);
  endtask
  // same strobes with aen high: a dma cycle that no i/o slave may take
  task automatic wr_dma(input logic [15:0] a, input logic [7:0] d);
    bus_write(a, d, 1'b1);
  endtask
  // one isa i/o write; lines held well past the 2-flop sync window
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d, input logic dma);
    @(posedge mclk);
    io_addr <= a;
    io_data <= d;
    io_aen <= dma;
    @(posedge mclk);
    io_write_n <= 1'b0;
    repeat (5) @(posedge mclk);
    io_write_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // released address and data lines show the inverse and aen returns high, so a stale value is never reused
    io_addr <= ~a;
    io_data <= ~d;
    io_aen <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb/io_port_watchdog_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module io_port_watchdog_timer_tb;
  logic mclk, rst, jmp, io_write_n, io_aen, cpu_reset_req, irq15, wdt_enabled;
  logic [15:0] io_addr;
  logic [7:0] io_data;
  int errors = 0;
  int n_compared = 0;
  int n;
  io_port_watchdog_timer #(.tick_cycles(10)) dut (.mclk(mclk), .rst(rst), .io_addr(io_addr),
    .io_data(io_data), .io_write_n(io_write_n), .io_aen(io_aen),
    .timeout_action_select_jumper(jmp), .cpu_reset_req(cpu_reset_req), .irq15(irq15),
    .wdt_enabled(wdt_enabled));
  isa_host host (.mclk(mclk), .io_addr(io_addr), .io_data(io_data), .io_write_n(io_write_n),
    .io_aen(io_aen));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  // 9 cycles pass inside the write task once the strobe falls; slack of 5 covers the sync delay
  task automatic cmp_time(input string name, input int iv, input int got);
    n_compared++;
    if (got + 9 < iv - iv / 20 || got + 9 > iv + iv / 20 + 5) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", name, iv, got + 9);
    end
  endtask
  task automatic wait_hi(input logic sel, output int k);
    k = 0;
    while ((sel ? irq15 : cpu_reset_req) !== 1'b1 && k < 8000) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_levels();
    @(posedge mclk);
    jmp <= 1'b1;
    for (int c = 15; c >= 0; c--) begin
      host.wr(16'h0443, {4'ha, c[3:0]});
      #1;
      cmp("enabled", 1'b1, wdt_enabled);
      cmp("irq cleared", 1'b0, irq15);
      wait_hi(1'b1, n);
      cmp_time("interval", (16 - c) * 200, n);
      #1;
      cmp("enabled after expiry", 1'b0, wdt_enabled);
    end
    host.wr(16'h0080, 8'h00);
    #1;
    cmp("irq after disable", 1'b0, irq15);
  endtask
  task automatic t_cpu_reset();
    @(posedge mclk);
    jmp <= 1'b0;
    host.wr(16'h0443, 8'h0f);
    wait_hi(1'b0, n);
    cmp_time("reset delay", 200, n);
    n = 0;
    while (cpu_reset_req === 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmp("pulse 50", 1'b1, n == 50);
    cmp("no irq", 1'b0, irq15);
  endtask
  task automatic t_restart();
    @(posedge mclk);
    jmp <= 1'b1;
    host.wr(16'h0443, 8'h01);
    repeat (1000) @(posedge mclk);
    host.wr(16'h0443, 8'h0f);
    wait_hi(1'b1, n);
    cmp_time("restart", 200, n);
  endtask
  task automatic t_disable();
    host.wr(16'h0444, 8'h0f);
    #1;
    cmp("other address", 1'b0, wdt_enabled);
    host.wr(16'h0443, 8'h0f);
    host.wr(16'h0080, 8'h5a);
    repeat (400) @(posedge mclk);
    cmp("no expiry", 1'b0, irq15 | cpu_reset_req | wdt_enabled);
    host.wr_dma(16'h0443, 8'h0f);
    #1;
    cmp("dma write ignored", 1'b0, wdt_enabled);
  endtask
  task automatic t_mid_reset();
    host.wr(16'h0443, 8'h0f);
    repeat (50) @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    cmp("idle after mid-run reset", 1'b0, cpu_reset_req | irq15 | wdt_enabled);
    repeat (250) @(posedge mclk);
    #1;
    cmp("no expiry after reset", 1'b0, cpu_reset_req | irq15 | wdt_enabled);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst <= 1'b1;
    jmp <= 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    cmp("idle after reset", 1'b0, cpu_reset_req | irq15 | wdt_enabled);
    t_levels();
    t_cpu_reset();
    t_restart();
    t_disable();
    t_mid_reset();
    end_of_test();
  end
  // about 29500 cycles expected; limit of 75000 leaves over twice that
  initial begin
    #1500000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
